/* shared/hmac_regs.vh */
// register offsets, control field positions and reset values of the multiply-accumulate unit
`ifndef HMAC_REGS_VH
`define HMAC_REGS_VH
`define HMAC_ADDR_W         4
`define HMAC_OFF_CTRL       4'h0
`define HMAC_OFF_OPA        4'h1
`define HMAC_OFF_OPB        4'h2
`define HMAC_OFF_ACC_UP     4'h3
`define HMAC_OFF_ACC_MID    4'h4
`define HMAC_OFF_ACC_LO     4'h5
`define HMAC_OFF_RES_MID    4'hB
`define HMAC_OFF_RES_LO     4'hC
`define HMAC_BIT_UNSIGNED   0
`define HMAC_BIT_OP_LO      1
`define HMAC_BIT_OP_HI      2
`define HMAC_BIT_START_MODE 3
`define HMAC_BIT_SELF_PROD  4
`define HMAC_BIT_CLEAR_ALL  5
`define HMAC_BIT_ACC_WCTL   6
`define HMAC_BIT_OVERFLOW   7
`define HMAC_OP_MUL         2'h0
`define HMAC_OP_ACC         2'h1
`define HMAC_OP_SUB         2'h2
`define HMAC_OP_NEG         2'h3
`define HMAC_CTRL_RST       8'h00
`define HMAC_W16_RST        16'h0000
`define HMAC_ACC_RST        48'h000000000000
`endif

/* tb/hmac_cpu_model.sv */
// processor-side model issuing register moves to the unit
`timescale 1ns/100ps
`default_nettype none
module hmac_cpu_model (
  input  wire         ref_clk_i,
  input  wire  [15:0] rd_data_i,
  output logic [3:0]  addr_o,
  output logic        wr_en_o,
  output logic [15:0] wr_data_o,
  output logic        rd_en_o
);
  initial begin
    addr_o = 4'h0;
    wr_en_o = 1'b0;
    wr_data_o = 16'h0000;
    rd_en_o = 1'b0;
  end
  // one-cycle write strobe, so an operand move is never taken twice and a
  // following read lands after the operation has updated the accumulator
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    rd_en_o = 1'b0;
    addr_o = a;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
  endtask
  // idle data is inverted so a stale value never looks valid
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    wr_data_o = ~wr_data_o;
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge ref_clk_i);
    rd_en_o = 1'b0;
    addr_o = ~a;
    d = rd_data_i;
  endtask
endmodule // hmac_cpu_model
`default_nettype wire

/* tb/hmac_unit_props.sv */
// checker of the multiply-accumulate unit register port
`timescale 1ns/100ps
`default_nettype none
module hmac_unit_props (
  input wire        ref_clk_i,
  input wire        rst_b_i,
  input wire [3:0]  addr_i,
  input wire        wr_en_i,
  input wire [15:0] wr_data_i,
  input wire        rd_en_i,
  input wire [15:0] rd_data_o,
  input wire        busy_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // writes are one-cycle pulses with an idle edge before the next move
  sequence s_clear;
    wr_en_i && addr_i == 4'h0 && wr_data_i[5] ##1 !wr_en_i
      ##1 rd_en_i && addr_i inside {[4'h1:4'h5]};
  endsequence
  sequence s_opnd;
    wr_en_i && addr_i inside {4'h1, 4'h2} ##1 !wr_en_i
      ##1 rd_en_i && addr_i == $past(addr_i, 2);
  endsequence
  sequence s_ctrl;
    wr_en_i && addr_i == 4'h0 ##1 !wr_en_i ##1 rd_en_i && addr_i == 4'h0;
  endsequence
  a_busy_low: assert property (busy_o == 1'b0) else $error("busy raised");
  a_rd_hold: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("read data moved");
  a_rd_reset: assert property (disable iff (1'b0) !rst_b_i |=> rd_data_o == 16'h0000)
    else $error("read data not cleared by reset");
  a_unmapped_zero: assert property (rd_en_i && !(addr_i inside {[4'h0:4'h5], 4'hB, 4'hC})
    |=> rd_data_o == 16'h0000) else $error("unmapped read not zero");
  a_ctrl_hi_zero: assert property (rd_en_i && addr_i == 4'h0
    |=> (rd_data_o & 16'hFF20) == 16'h0000) else $error("control upper or clear bit read set");
  a_ctrl_echo: assert property (s_ctrl
    |=> (rd_data_o & 16'h005F) == ($past(wr_data_i, 3) & 16'h005F))
    else $error("control field readback wrong");
  a_opnd_echo: assert property (s_opnd |=> rd_data_o == $past(wr_data_i, 3))
    else $error("operand readback wrong");
  a_clear_zero: assert property (s_clear |=> rd_data_o == 16'h0000) else $error("clear left data");
endmodule // hmac_unit_props
bind hmac_unit hmac_unit_props u_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .busy_o(busy_o));
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin m.rd(a, v); checked++; if (v !== (e)) begin error_cnt++; \
  $display("mismatch reg_%h exp %h got %h", a, e, v); end end
module tb_top;
  logic        clk;
  logic        rst_b;
  wire  [3:0]  addr;
  wire         we;
  wire         re;
  wire  [15:0] wd;
  wire  [15:0] rdd;
  logic [15:0] v;
  int          error_cnt = 0;
  int          checked = 0;
  hmac_cpu_model m (.ref_clk_i(clk), .rd_data_i(rdd), .addr_o(addr), .wr_en_o(we),
    .wr_data_o(wd), .rd_en_o(re));
  hmac_unit uut (.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wr_en_i(we),
    .wr_data_i(wd), .rd_en_i(re), .rd_data_o(rdd), .busy_o());
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_walk;
    m.wr(4'h0, 16'h0021);
    m.wr(4'h1, 16'h1234);
    `CHK(4'h1, 16'h1234)
    m.wr(4'h2, 16'h0055);
    `CHK(4'h5, 16'h0B44)
    `CHK(4'h4, 16'h0006)
    `CHK(4'h3, 16'h0000)
    `CHK(4'hB, 16'h0006)
    `CHK(4'hC, 16'h0B44)
    $display("test walk done");
  endtask
  task automatic t_signed;
    m.wr(4'h0, 16'h0022);
    m.wr(4'h1, 16'hFFFF);
    m.wr(4'h2, 16'h0003);
    `CHK(4'h3, 16'hFFFF)
    m.wr(4'h2, 16'h0005);
    m.wr(4'h1, 16'h0002);
    `CHK(4'h5, 16'h0007)
    `CHK(4'h3, 16'h0000)
    m.wr(4'h0, 16'h0024);
    m.wr(4'h1, 16'h0002);
    m.wr(4'h2, 16'h0003);
    `CHK(4'h5, 16'hFFFA)
    m.wr(4'h0, 16'h0006);
    m.wr(4'h1, 16'h0004);
    m.wr(4'h2, 16'h0005);
    `CHK(4'h5, 16'hFFEC)
    `CHK(4'h4, 16'hFFFF)
    $display("test signed done");
  endtask
  task automatic t_ovf_wctl;
    m.wr(4'h0, 16'h0025);
    m.wr(4'h1, 16'h0002);
    m.wr(4'h2, 16'h0003);
    `CHK(4'h0, 16'h0085)
    m.wr(4'h0, 16'h0061);
    m.wr(4'h1, 16'h0003);
    m.wr(4'h2, 16'h0004);
    `CHK(4'h5, 16'h0000)
    `CHK(4'hC, 16'h000C)
    m.wr(4'hB, 16'hFFFF);
    `CHK(4'hB, 16'h0000)
    `CHK(4'h6, 16'h0000)
    $display("test overflow and write control done");
  endtask
  task automatic t_modes;
    m.wr(4'h0, 16'h0029);
    `CHK(4'h0, 16'h0009)
    m.wr(4'h1, 16'h0003);
    m.wr(4'h2, 16'h0004);
    `CHK(4'h5, 16'h0000)
    m.wr(4'h0, 16'h0031);
    `CHK(4'h1, 16'h0000)
    m.wr(4'h1, 16'h0007);
    `CHK(4'h5, 16'h0031)
    // unsigned code 11 has no negate and must act as a plain multiply
    m.wr(4'h0, 16'h0027);
    m.wr(4'h1, 16'h0002);
    m.wr(4'h2, 16'h0003);
    `CHK(4'h5, 16'h0006)
    $display("test modes done");
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_walk();
    t_signed();
    t_ovf_wctl();
    t_modes();
    complete_run();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire

/* verilog/hmac_mul_core.v */
// combinational 16x16 multiply with 48-bit accumulate, subtract and negate
`timescale 1ns/100ps
`default_nettype none
`include "hmac_regs.vh"
module hmac_mul_core (
  input  wire [15:0] opa_i,
  input  wire [15:0] opb_i,
  input  wire [47:0] acc_i,
  input  wire [1:0]  op_i,
  input  wire        unsigned_i,
  output reg  [47:0] result_o,
  output reg         overflow_o
);
  reg  [48:0] ext_a;
  reg  [48:0] ext_b;
  reg  [48:0] prod;
  reg  [48:0] acc_x;
  reg  [48:0] sum;

  // operands extended to 49 bits and accumulator by one bit so the 48-bit range check sees the carry
  function [48:0] ext16;
    input [15:0] v;
    input        uns;
    begin
      ext16 = uns ? {33'h000000000, v} : {{33{v[15]}}, v};
    end
  endfunction

  always @* begin
    ext_a = ext16(opa_i, unsigned_i);
    ext_b = ext16(opb_i, unsigned_i);
    prod  = ext_a * ext_b;
    acc_x = unsigned_i ? {1'b0, acc_i} : {acc_i[47], acc_i};
    overflow_o = 1'b0;
    case (op_i)
      `HMAC_OP_MUL: sum = prod;
      `HMAC_OP_ACC: sum = acc_x + prod;
      `HMAC_OP_SUB: sum = acc_x - prod;
      `HMAC_OP_NEG: sum = 49'h0 - prod;
      default:      sum = prod;
    endcase
    result_o = sum[47:0];
    if (op_i == `HMAC_OP_ACC || op_i == `HMAC_OP_SUB) begin
      // unsigned: carry/borrow out; signed: the two top bits disagree
      overflow_o = unsigned_i ? sum[48] : (sum[48] ^ sum[47]);
    end
  end
endmodule // hmac_mul_core
`default_nettype wire

/* verilog/hmac_unit.v */
// memory-mapped multiply-accumulate unit with register-move access
`timescale 1ns/100ps
`default_nettype none
`include "hmac_regs.vh"
module hmac_unit (
  input  wire        ref_clk_i,
  input  wire        rst_b_i,
  input  wire [3:0]  addr_i,
  input  wire        wr_en_i,
  input  wire [15:0] wr_data_i,
  input  wire        rd_en_i,
  output reg  [15:0] rd_data_o,
  output wire        busy_o
);
  reg  [7:0]  ctrl_r;
  reg  [15:0] opa_r;
  reg  [15:0] opb_r;
  reg  [47:0] acc_r;
  reg  [31:0] res_r;
  reg         opa_seen_r;
  reg         opb_seen_r;
  reg         start_r;
  wire [47:0] result;
  wire        ovf;
  wire [15:0] opb_eff;
  wire        wr_ctrl;
  wire        wr_opa;
  wire        wr_opb;
  wire        start_auto;
  reg  [1:0]  op_eff;

  function hit;
    input [3:0] off;
    begin
      hit = wr_en_i && (addr_i == off);
    end
  endfunction

  assign wr_ctrl = hit(`HMAC_OFF_CTRL);
  assign wr_opa  = hit(`HMAC_OFF_OPA);
  assign wr_opb  = hit(`HMAC_OFF_OPB);
  // single-cycle datapath, never stalls
  assign busy_o  = 1'b0;

  // squaring feeds operand A to both multiplier inputs
  assign opb_eff = ctrl_r[`HMAC_BIT_SELF_PROD] ? opa_r : opb_r;

  // second operand write completes the pair; in square mode operand A alone suffices
  assign start_auto = !ctrl_r[`HMAC_BIT_START_MODE] &&
                      ((wr_opb && (opa_seen_r || wr_opa)) ||
                       (wr_opa && (opb_seen_r || ctrl_r[`HMAC_BIT_SELF_PROD])));

  // negate only exists as a signed operation; unsigned code 11 behaves as multiply
  always @* begin
    op_eff = ctrl_r[`HMAC_BIT_OP_HI:`HMAC_BIT_OP_LO];
    if (ctrl_r[`HMAC_BIT_UNSIGNED] && op_eff == `HMAC_OP_NEG) begin
      op_eff = `HMAC_OP_MUL;
    end
  end

  hmac_mul_core u_core (
    .opa_i      (opa_r),
    .opb_i      (opb_eff),
    .acc_i      (acc_r),
    .op_i       (op_eff),
    .unsigned_i (ctrl_r[`HMAC_BIT_UNSIGNED]),
    .result_o   (result),
    .overflow_o (ovf)
  );

  // operands are latched this cycle; the operation runs on the next edge from the registers
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r     <= `HMAC_CTRL_RST;
      opa_r      <= `HMAC_W16_RST;
      opb_r      <= `HMAC_W16_RST;
      acc_r      <= `HMAC_ACC_RST;
      res_r      <= 32'h00000000;
      opa_seen_r <= 1'b0;
      opb_seen_r <= 1'b0;
      start_r    <= 1'b0;
    end else begin
      start_r <= start_auto;
      if (wr_opa) begin
        opa_r      <= wr_data_i;
        opa_seen_r <= !start_auto;
      end
      if (wr_opb) begin
        opb_r      <= wr_data_i;
        opb_seen_r <= !start_auto;
      end
      if (start_auto) begin
        opa_seen_r <= 1'b0;
        opb_seen_r <= 1'b0;
      end
      case (addr_i)
        `HMAC_OFF_ACC_UP:  if (wr_en_i) acc_r[47:32] <= wr_data_i;
        `HMAC_OFF_ACC_MID: if (wr_en_i) acc_r[31:16] <= wr_data_i;
        `HMAC_OFF_ACC_LO:  if (wr_en_i) acc_r[15:0]  <= wr_data_i;
        default: ;
      endcase
      if (start_r) begin
        res_r <= result[31:0];
        if (!ctrl_r[`HMAC_BIT_ACC_WCTL]) begin
          acc_r <= result;
        end
        // held-off accumulator still reports overflow of the computed value
        ctrl_r[`HMAC_BIT_OVERFLOW] <= ovf;
      end
      if (wr_ctrl) begin
        // overflow is read-only; clear-all is an action and does not stick
        ctrl_r[6:0] <= {wr_data_i[6], 1'b0, wr_data_i[4:0]};
        if (wr_data_i[`HMAC_BIT_CLEAR_ALL]) begin
          opa_r      <= `HMAC_W16_RST;
          opb_r      <= `HMAC_W16_RST;
          acc_r      <= `HMAC_ACC_RST;
          opa_seen_r <= 1'b0;
          opb_seen_r <= 1'b0;
        end
      end
    end
  end

  // read data is registered: valid the cycle after rd_en_i
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= `HMAC_W16_RST;
    end else if (rd_en_i) begin
      case (addr_i)
        `HMAC_OFF_CTRL:    rd_data_o <= {8'h00, ctrl_r};
        `HMAC_OFF_OPA:     rd_data_o <= opa_r;
        `HMAC_OFF_OPB:     rd_data_o <= opb_r;
        `HMAC_OFF_ACC_UP:  rd_data_o <= acc_r[47:32];
        `HMAC_OFF_ACC_MID: rd_data_o <= acc_r[31:16];
        `HMAC_OFF_ACC_LO:  rd_data_o <= acc_r[15:0];
        `HMAC_OFF_RES_MID: rd_data_o <= res_r[31:16];
        `HMAC_OFF_RES_LO:  rd_data_o <= res_r[15:0];
        default:           rd_data_o <= `HMAC_W16_RST;
      endcase
    end
  end
endmodule // hmac_unit
`default_nettype wire
